//--- rtl/tsr_consts.vh
// Constants shared by the thermal sensor register set.
`ifndef TSR_CONSTS_VH
`define TSR_CONSTS_VH

// ----------------------------------------------------------------
// Register selector codes (pointer byte, low three bits)
// ----------------------------------------------------------------
`define TSR_PTR_TEMP      3'h0
`define TSR_PTR_SETTINGS  3'h1
`define TSR_PTR_RELEASE   3'h2
`define TSR_PTR_OVER      3'h3
`define TSR_PTR_INTERVAL  3'h4

// ----------------------------------------------------------------
// Settings field positions
// ----------------------------------------------------------------
`define TSR_SET_SHUTDOWN  0
`define TSR_SET_MODE      1
`define TSR_SET_POLARITY  2
`define TSR_SET_QUEUE_LO  3
`define TSR_SET_QUEUE_HI  4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TSR_RST_SETTINGS  8'h00
`define TSR_RST_TEMP      11'h000
`define TSR_RST_OVER      9'h0a0
`define TSR_RST_RELEASE   9'h096
`define TSR_RST_INTERVAL  5'h01
`define TSR_RST_ADDR      7'h48

// ----------------------------------------------------------------
// Fault queue depths per code
// ----------------------------------------------------------------
`define TSR_QUEUE_D0      3'h1
`define TSR_QUEUE_D1      3'h2
`define TSR_QUEUE_D2      3'h4
`define TSR_QUEUE_D3      3'h6

`endif

//--- rtl/tsr_alert_engine.v
// Alert engine: fault queue, comparator and interrupt modes, pin polarity.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.vh"

module tsr_alert_engine (
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Conversion result
   input  wire       convDone,
   input  wire [8:0] tempTop,
   // Limits and settings
   input  wire [8:0] overLimit,
   input  wire [8:0] releaseLimit,
   input  wire [1:0] faultQueueDepth,
   input  wire       alertModeSelect,
   input  wire       alertPolarity,
   input  wire       shutdown,
   // Register read notice
   input  wire       readEvent,
   // Alert pin
   output reg        alertOeN,
   output wire       alertActive
);

   // ----------------------------------------------------------------
   // Depth decode
   // ----------------------------------------------------------------
   function [2:0] queueDepth;
      input [1:0] code;
      begin
         case (code)
            2'h0:    queueDepth = `TSR_QUEUE_D0;
            2'h1:    queueDepth = `TSR_QUEUE_D1;
            2'h2:    queueDepth = `TSR_QUEUE_D2;
            default: queueDepth = `TSR_QUEUE_D3;
         endcase
      end
   endfunction

   reg  [2:0] faultCnt_r;
   reg        compState_r;
   reg        intState_r;
   reg        hiZone_r;
   reg        shutdownPrev_r;

   wire       lookHigh  = alertModeSelect ? ~hiZone_r : ~compState_r;
   wire       overTrip  = $signed(tempTop) > $signed(overLimit);
   wire       underTrip = $signed(tempTop) < $signed(releaseLimit);
   wire       tripCond  = lookHigh ? overTrip : underTrip;
   wire [2:0] cntInc    = faultCnt_r + 3'h1;
   wire       fire      = convDone & tripCond & (cntInc >= queueDepth(faultQueueDepth));
   wire       intClear  = readEvent | (shutdown & ~shutdownPrev_r);

   // ----------------------------------------------------------------
   // Alert state
   // ----------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         faultCnt_r     <= 3'h0;
         compState_r    <= 1'b0;
         intState_r     <= 1'b0;
         hiZone_r       <= 1'b0;
         shutdownPrev_r <= 1'b0;
      end else begin
         shutdownPrev_r <= shutdown;
         if (convDone) begin
            if (fire | ~tripCond)
               faultCnt_r <= 3'h0;
            else
               faultCnt_r <= cntInc;
         end
         if (fire & ~alertModeSelect)
            compState_r <= ~compState_r;
         // A new trip beats a clear landing in the same cycle.
         if (fire & alertModeSelect) begin
            intState_r <= 1'b1;
            hiZone_r   <= ~hiZone_r;
         end else if (intClear & alertModeSelect) begin
            intState_r <= 1'b0;
         end
      end
   end

   assign alertActive = alertModeSelect ? intState_r : compState_r;

   // The pin is open drain, so a high level is only the pull-up.
   always @(posedge clk or posedge rst) begin
      if (rst)
         alertOeN <= 1'b1;
      else
         alertOeN <= ~(alertActive ^ alertPolarity);
   end

endmodule // tsr_alert_engine

`default_nettype wire

//--- rtl/tsr_register_set.v
// Register set of the temperature sensor with its two-wire serial slave.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.vh"

module tsr_register_set #(
   parameter [6:0] SLAVE_ADDR = `TSR_RST_ADDR
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Two-wire serial pins
   input  wire        sclIn,
   input  wire        sdaIn,
   output wire        sdaOut,
   output reg         sdaOeN,
   // Converter side
   input  wire        convDone,
   input  wire [10:0] convResult,
   // Alert pin
   output wire        alertOut,
   output wire        alertOeN,
   // Status toward the rest of the device
   output wire        alertActive,
   output wire        shutdownMode,
   output wire [4:0]  sampleInterval
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_ADDR  = 3'h1;
   localparam [2:0] ST_AACK  = 3'h2;
   localparam [2:0] ST_WBYTE = 3'h3;
   localparam [2:0] ST_WACK  = 3'h4;
   localparam [2:0] ST_RDATA = 3'h5;
   localparam [2:0] ST_RACK  = 3'h6;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg  [7:0]  settings_r;
   reg  [10:0] temp_r;
   reg  [8:0]  over_r;
   reg  [8:0]  release_r;
   reg  [4:0]  interval_r;
   reg  [2:0]  ptr_r;

   reg  [2:0]  state_r;
   reg  [3:0]  bitCnt_r;
   reg  [7:0]  rxShift_r;
   reg  [7:0]  txShift_r;
   reg  [15:0] snap_r;
   reg         byteSel_r;
   reg         firstByte_r;
   reg         readDir_r;
   reg         masterAck_r;
   reg         readEvent_r;

   reg         sclS1_r;
   reg         sclS2_r;
   reg         sclS3_r;
   reg         sdaS1_r;
   reg         sdaS2_r;
   reg         sdaS3_r;

   // ----------------------------------------------------------------
   // Read word view of each register
   // ----------------------------------------------------------------
   function [15:0] readWord;
      input [2:0]  ptr;
      input [7:0]  setv;
      input [10:0] tmp;
      input [8:0]  ovr;
      input [8:0]  rel;
      input [4:0]  ivl;
      begin
         case (ptr)
            `TSR_PTR_TEMP:     readWord = {tmp, 5'h00};
            `TSR_PTR_SETTINGS: readWord = {setv, setv};
            `TSR_PTR_RELEASE:  readWord = {rel, 7'h00};
            `TSR_PTR_OVER:     readWord = {ovr, 7'h00};
            `TSR_PTR_INTERVAL: readWord = {3'h0, ivl, 3'h0, ivl};
            default:           readWord = 16'h0000;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers and bus events
   // ----------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sclS1_r <= 1'b1;
         sclS2_r <= 1'b1;
         sclS3_r <= 1'b1;
         sdaS1_r <= 1'b1;
         sdaS2_r <= 1'b1;
         sdaS3_r <= 1'b1;
      end else begin
         sclS1_r <= sclIn;
         sclS2_r <= sclS1_r;
         sclS3_r <= sclS2_r;
         sdaS1_r <= sdaIn;
         sdaS2_r <= sdaS1_r;
         sdaS3_r <= sdaS2_r;
      end
   end

   wire sclRise  = sclS2_r & ~sclS3_r;
   wire sclFall  = ~sclS2_r & sclS3_r;
   wire busStart = sclS2_r & sclS3_r & sdaS3_r & ~sdaS2_r;
   wire busStop  = sclS2_r & sclS3_r & ~sdaS3_r & sdaS2_r;

   wire [15:0] liveWord = readWord(ptr_r, settings_r, temp_r, over_r, release_r, interval_r);

   // ----------------------------------------------------------------
   // Conversion capture
   // ----------------------------------------------------------------
   // Conversions stop in shutdown, so a stray done strobe is dropped there.
   wire convTake = convDone & ~settings_r[`TSR_SET_SHUTDOWN];

   always @(posedge clk or posedge rst) begin
      if (rst)
         temp_r <= `TSR_RST_TEMP;
      else if (convTake)
         temp_r <= convResult;
   end

   // ----------------------------------------------------------------
   // Serial slave
   // ----------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         settings_r  <= `TSR_RST_SETTINGS;
         over_r      <= `TSR_RST_OVER;
         release_r   <= `TSR_RST_RELEASE;
         interval_r  <= `TSR_RST_INTERVAL;
         ptr_r       <= `TSR_PTR_TEMP;
         state_r     <= ST_IDLE;
         bitCnt_r    <= 4'h0;
         rxShift_r   <= 8'h00;
         txShift_r   <= 8'h00;
         snap_r      <= 16'h0000;
         byteSel_r   <= 1'b0;
         firstByte_r <= 1'b0;
         readDir_r   <= 1'b0;
         masterAck_r <= 1'b0;
         readEvent_r <= 1'b0;
         sdaOeN      <= 1'b1;
      end else begin
         readEvent_r <= 1'b0;
         if (busStart) begin
            state_r  <= ST_ADDR;
            bitCnt_r <= 4'h0;
            sdaOeN   <= 1'b1;
         end else if (busStop) begin
            // A stop after any byte leaves the slave ready again.
            state_r <= ST_IDLE;
            sdaOeN  <= 1'b1;
         end else begin
            case (state_r)
               ST_ADDR, ST_WBYTE: begin
                  if (sclRise) begin
                     rxShift_r <= {rxShift_r[6:0], sdaS2_r};
                     bitCnt_r  <= bitCnt_r + 4'h1;
                  end else if (sclFall && bitCnt_r == 4'h8) begin
                     if (state_r == ST_ADDR) begin
                        if (rxShift_r[7:1] == SLAVE_ADDR) begin
                           sdaOeN    <= 1'b0;
                           readDir_r <= rxShift_r[0];
                           state_r   <= ST_AACK;
                        end else begin
                           state_r <= ST_IDLE;
                        end
                     end else begin
                        sdaOeN  <= 1'b0;
                        state_r <= ST_WACK;
                        if (firstByte_r) begin
                           ptr_r       <= rxShift_r[2:0];
                           firstByte_r <= 1'b0;
                           byteSel_r   <= 1'b0;
                        end else begin
                           byteSel_r <= ~byteSel_r;
                           case (ptr_r)
                              `TSR_PTR_SETTINGS: settings_r <= rxShift_r;
                              `TSR_PTR_INTERVAL: interval_r <= rxShift_r[4:0];
                              `TSR_PTR_OVER: begin
                                 if (byteSel_r)
                                    over_r[0] <= rxShift_r[7];
                                 else
                                    over_r[8:1] <= rxShift_r;
                              end
                              `TSR_PTR_RELEASE: begin
                                 if (byteSel_r)
                                    release_r[0] <= rxShift_r[7];
                                 else
                                    release_r[8:1] <= rxShift_r;
                              end
                              default: begin
                                 // Temperature and unused codes keep their contents.
                                 settings_r <= settings_r;
                              end
                           endcase
                        end
                     end
                  end
               end
               ST_AACK: begin
                  if (sclFall) begin
                     bitCnt_r <= 4'h0;
                     if (readDir_r) begin
                        // One snapshot serves the whole read.
                        snap_r      <= liveWord;
                        txShift_r   <= liveWord[15:8];
                        sdaOeN      <= liveWord[15];
                        byteSel_r   <= 1'b1;
                        readEvent_r <= 1'b1;
                        state_r     <= ST_RDATA;
                     end else begin
                        sdaOeN      <= 1'b1;
                        firstByte_r <= 1'b1;
                        state_r     <= ST_WBYTE;
                     end
                  end
               end
               ST_WACK: begin
                  if (sclFall) begin
                     sdaOeN   <= 1'b1;
                     bitCnt_r <= 4'h0;
                     state_r  <= ST_WBYTE;
                  end
               end
               ST_RDATA: begin
                  if (sclRise) begin
                     bitCnt_r <= bitCnt_r + 4'h1;
                  end else if (sclFall) begin
                     if (bitCnt_r == 4'h8) begin
                        sdaOeN  <= 1'b1;
                        state_r <= ST_RACK;
                     end else begin
                        txShift_r <= {txShift_r[6:0], 1'b0};
                        sdaOeN    <= txShift_r[6];
                     end
                  end
               end
               ST_RACK: begin
                  if (sclRise) begin
                     masterAck_r <= ~sdaS2_r;
                  end else if (sclFall) begin
                     bitCnt_r <= 4'h0;
                     if (masterAck_r) begin
                        // Bytes alternate high then low of the snapshot.
                        txShift_r <= byteSel_r ? snap_r[7:0] : snap_r[15:8];
                        sdaOeN    <= byteSel_r ? snap_r[7] : snap_r[15];
                        byteSel_r <= ~byteSel_r;
                        state_r   <= ST_RDATA;
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  sdaOeN <= 1'b1;
               end
            endcase
         end
      end
   end

   assign sdaOut = 1'b0;

   // ----------------------------------------------------------------
   // Alert
   // ----------------------------------------------------------------
   tsr_alert_engine u_alert (
      .clk             (clk),
      .rst             (rst),
      .convDone        (convTake),
      .tempTop         (convResult[10:2]),
      .overLimit       (over_r),
      .releaseLimit    (release_r),
      .faultQueueDepth (settings_r[`TSR_SET_QUEUE_HI:`TSR_SET_QUEUE_LO]),
      .alertModeSelect (settings_r[`TSR_SET_MODE]),
      .alertPolarity   (settings_r[`TSR_SET_POLARITY]),
      .shutdown        (settings_r[`TSR_SET_SHUTDOWN]),
      .readEvent       (readEvent_r),
      .alertOeN        (alertOeN),
      .alertActive     (alertActive)
   );

   assign alertOut       = 1'b0;
   assign shutdownMode   = settings_r[`TSR_SET_SHUTDOWN];
   assign sampleInterval = interval_r;

endmodule // tsr_register_set

`default_nettype wire

//--- testbench/tsr_register_set_monitor.sv
// Port checker for the thermal sensor register set.
`timescale 1ns/1ps
`default_nettype none
module tsr_register_set_monitor (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Serial pins
   input wire logic        sclIn,
   input wire logic        sdaIn,
   input wire logic        sdaOut,
   input wire logic        sdaOeN,
   // Converter and status
   input wire logic        convDone,
   input wire logic [10:0] convResult,
   input wire logic        alertOut,
   input wire logic        alertOeN,
   input wire logic        alertActive,
   input wire logic        shutdownMode,
   input wire logic [4:0]  sampleInterval
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   reset_defaults_a: assert property ($past(rst) |-> alertOeN && !alertActive && !shutdownMode)
      else $error("outputs not at defaults after reset");
   open_drain_a: assert property (sdaOut == 1'b0 && alertOut == 1'b0)
      else $error("open drain value not low");
   // A change of the data line while the clock is high would read as a start or stop.
   sda_scl_low_a: assert property ($changed(sdaOeN) |-> !sclIn)
      else $error("data line changed while serial clock high");
   alert_rise_a: assert property ($rose(alertActive) |-> $past(convDone))
      else $error("alert rose without a conversion");
   alert_shutdown_a: assert property ($rose(alertActive) |-> !$past(shutdownMode))
      else $error("alert rose while shut down");
   alert_fall_a: assert property ($fell(alertActive) |-> $past(convDone) || !sclIn || shutdownMode)
      else $error("alert fell without a cause");
   alert_pin_a: assert property ($changed(alertActive) |=> $changed(alertOeN))
      else $error("alert pin did not follow alert state");
   settings_bus_a: assert property ($changed(shutdownMode) |-> !sclIn)
      else $error("settings changed outside a bus write");
   interval_bus_a: assert property ($changed(sampleInterval) |-> !sclIn)
      else $error("interval changed outside a bus write");

   cover property ($rose(alertActive));
   cover property ($fell(alertActive) && !sclIn);
   cover property ($rose(shutdownMode));
endmodule // tsr_register_set_monitor

bind tsr_register_set tsr_register_set_monitor u_mon (
   .clk(clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
   .convDone(convDone), .convResult(convResult), .alertOut(alertOut), .alertOeN(alertOeN),
   .alertActive(alertActive), .shutdownMode(shutdownMode), .sampleInterval(sampleInterval)
);
`default_nettype wire

//--- testbench/tsr_bus_host.sv
// Two-wire bus controller model that reads and writes the sensor registers.
`timescale 1ns/1ps
`default_nettype none
module tsr_bus_host (
   // Clock and bus
   input  wire logic clk,
   input  wire logic sdaLine,
   output var  logic sclOut,
   output var  logic sdaOut
);
   localparam logic [6:0] DEV_ADDR = 7'h48;
   logic ackOk;

   initial begin
      sclOut = 1'b1;
      sdaOut = 1'b1;
      ackOk  = 1'b1;
   end

   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Data moves only while the clock is low; one bit takes 80 ns.
   task automatic bitx(input logic b, output logic r);
      sdaOut <= b;
      waitc(4);
      sclOut <= 1'b1;
      waitc(8);
      r = sdaLine;
      sclOut <= 1'b0;
      waitc(4);
   endtask

   task automatic start();
      sdaOut <= 1'b0;
      waitc(8);
      sclOut <= 1'b0;
      waitc(4);
   endtask

   task automatic stop();
      sdaOut <= 1'b0;
      waitc(4);
      sclOut <= 1'b1;
      waitc(8);
      sdaOut <= 1'b1;
      waitc(8);
   endtask

   task automatic sendb(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(b[i], r);
      bitx(1'b1, r);
      ackOk = ackOk & ~r;
   endtask

   task automatic recvb(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, r);
         b[i] = r;
      end
      bitx(last, r);
   endtask

   task automatic wr(input logic [2:0] ptr, input int n, input logic [15:0] d);
      start();
      sendb({DEV_ADDR, 1'b0});
      sendb({5'h00, ptr});
      if (n > 0)
         sendb(d[15:8]);
      if (n > 1)
         sendb(d[7:0]);
      stop();
   endtask

   // Bytes arrive high first; the last one is refused so the device lets go.
   task automatic rd(input int n, output logic [15:0] d);
      d = 16'h0000;
      start();
      sendb({DEV_ADDR, 1'b1});
      recvb(n == 1, d[15:8]);
      if (n > 1)
         recvb(1'b1, d[7:0]);
      stop();
   endtask
endmodule // tsr_bus_host
`default_nettype wire

//--- testbench/tb_tsr_register_set.sv
// Self-checking bench for the thermal sensor register set.
`timescale 1ns/1ps
`default_nettype none
module tb_tsr_register_set;
   logic        clk;
   logic        rst;
   logic        convDone;
   logic [10:0] convResult;
   logic        hostScl;
   logic        hostSda;
   logic        sdaLine;
   logic        sdaOut;
   logic        sdaOeN;
   logic        alertOut;
   logic        alertOeN;
   logic        alertActive;
   logic        shutdownMode;
   logic [4:0]  sampleInterval;
   logic [15:0] rdata;
   int          errors;
   int          compares;
   localparam logic [10:0] HOT  = 11'h284;
   localparam logic [10:0] COLD = 11'h254;

   assign sdaLine = hostSda & (sdaOeN | sdaOut);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   tsr_register_set u_dut (
      .clk(clk), .rst(rst), .sclIn(hostScl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
      .convDone(convDone), .convResult(convResult), .alertOut(alertOut), .alertOeN(alertOeN),
      .alertActive(alertActive), .shutdownMode(shutdownMode), .sampleInterval(sampleInterval)
   );
   tsr_bus_host u_host (.clk(clk), .sdaLine(sdaLine), .sclOut(hostScl), .sdaOut(hostSda));

   // ----
   // Helpers
   // ----
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic conv(input logic [10:0] v);
      @(posedge clk);
      convDone   <= 1'b1;
      convResult <= v;
      @(posedge clk);
      convDone <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic rdAt(input logic [2:0] p, input int n, output logic [15:0] d);
      u_host.wr(p, 0, 16'h0000);
      u_host.rd(n, d);
   endtask

   task automatic setCfg(input logic [7:0] v);
      u_host.wr(3'h1, 1, {v, 8'h00});
   endtask

   task automatic chkAlert(input logic exp);
      check("alert", {15'h0000, alertActive}, {15'h0000, exp});
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_defaults();
      u_host.rd(2, rdata);
      check("temp default", rdata, 16'h0000);
      rdAt(3'h1, 1, rdata);
      check("settings default", rdata, 16'h0000);
      rdAt(3'h2, 2, rdata);
      check("release default", rdata, 16'h4b00);
      rdAt(3'h3, 2, rdata);
      check("over default", rdata, 16'h5000);
      rdAt(3'h5, 1, rdata);
      check("unused pointer", rdata, 16'h0000);
      u_host.wr(3'h4, 1, 16'h1f00);
      check("interval", {11'h000, sampleInterval}, 16'h001f);
   endtask

   task automatic t_settings();
      setCfg(8'he1);
      rdAt(3'h1, 1, rdata);
      check("settings", rdata, 16'he100);
      check("shutdown", {15'h0000, shutdownMode}, 16'h0001);
      conv(HOT);
      chkAlert(1'b0);
      rdAt(3'h0, 2, rdata);
      check("temp frozen", rdata, 16'h0000);
      setCfg(8'he0);
      conv(HOT);
      chkAlert(1'b1);
      conv(COLD);
      chkAlert(1'b0);
      setCfg(8'h00);
   endtask

   task automatic t_temp();
      conv(11'h649);
      rdAt(3'h0, 2, rdata);
      check("temp", rdata, 16'hc920);
      check("legacy nine bits", {7'h00, rdata[15:7]}, 16'h0192);
      u_host.rd(1, rdata);
      check("temp high byte", rdata, 16'hc900);
      u_host.wr(3'h0, 2, 16'h1234);
      // A conversion lands in mid-read; the read must stay on one result.
      fork
         u_host.rd(2, rdata);
         begin
            repeat (200) @(posedge clk);
            conv(11'h0c8);
         end
      join
      check("temp snapshot", rdata, 16'hc920);
      u_host.rd(2, rdata);
      check("temp new", rdata, 16'h1900);
      u_host.wr(3'h3, 2, 16'h1aff);
      u_host.rd(2, rdata);
      check("limit", rdata, 16'h1a80);
      u_host.rd(1, rdata);
      check("limit byte", rdata, 16'h1a00);
      u_host.wr(3'h3, 2, 16'h5000);
   endtask

   task automatic t_queue();
      int dep[4] = '{1, 2, 4, 6};
      conv(11'h282);
      chkAlert(1'b0);
      for (int c = 0; c < 4; c++) begin
         setCfg({3'h0, c[1:0], c[0], 2'h0});
         repeat (dep[c] - 1) conv(HOT);
         chkAlert(1'b0);
         conv(HOT);
         chkAlert(1'b1);
         check("alert pin", {15'h0000, alertOeN}, {15'h0000, c[0]});
         u_host.rd(1, rdata);
         chkAlert(1'b1);
         // Shutdown must leave a comparator alert where it stands.
         setCfg({3'h0, c[1:0], c[0], 2'h1});
         chkAlert(1'b1);
         setCfg({3'h0, c[1:0], c[0], 2'h0});
         repeat (dep[c]) conv(COLD);
         chkAlert(1'b0);
      end
      setCfg(8'h00);
   endtask

   task automatic t_interrupt();
      setCfg(8'h02);
      conv(HOT);
      conv(HOT);
      chkAlert(1'b1);
      u_host.rd(1, rdata);
      chkAlert(1'b0);
      conv(COLD);
      chkAlert(1'b1);
      u_host.rd(1, rdata);
      chkAlert(1'b0);
      conv(HOT);
      setCfg(8'h03);
      chkAlert(1'b0);
      setCfg(8'h00);
   endtask

   initial begin
      rst        = 1'b1;
      convDone   = 1'b0;
      convResult = 11'h000;
      errors     = 0;
      compares   = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_defaults();
      t_settings();
      t_temp();
      t_queue();
      t_interrupt();
      check("acks", {15'h0000, u_host.ackOk}, 16'h0001);
      report_and_stop();
   end

   initial begin
      repeat (95000) @(posedge clk);
      errors++;
      report_and_stop();
   end
endmodule // tb_tsr_register_set
`default_nettype wire
